// File: src/bert_rx_pkg.sv
// Notes on behaviour
// [RULE1] every received data bit advances the 32-bit bit counter by one.
// [RULE2] every received bit that misses the expected pattern advances the error counter.
// [RULE3] both counters stop at all ones and never wrap.
// [RULE4] counting starts at first lock and goes on after lock is lost.
// [RULE5] a low-to-high toggle of the latch-clear bit zeroes both counters.
// [RULE6] host should toggle latch-clear at lock and at period end.
// [RULE7] live lock status rises after 32 consecutive matching bit positions.
// [RULE8] live lock drops when six of 64 bits err; search restarts.
// [RULE9] error-count saturation flag latches, clears on read, sets once per saturation.
// [RULE10] bit-count saturation flag latches, clears on read, sets once per saturation.
// [RULE11] either saturation flag interrupts when its enable and top mask are set.
// [RULE12] bit-error flag latches on errors while locked only, clears on read.
// [RULE13] bit-error flag interrupts when its enable and top mask are set.
// [RULE14] lock-lost flag sets on search start, holds until software reads it; here it is also set while unlocked, and a read clears it only when locked.
// [RULE15] any lock change interrupts with its enable and top mask set.
// [RULE16] all-zeros flag latches after 31 zeros, clears only after a one.
// [RULE17] all-ones flag latches after 31 ones, clears only after a zero.
// [RULE18] error count low byte sits in status bits 15:8, rest next register.
// [RULE19] control bits 13, 14, 15 enable saturation, bit-error, lock-change interrupts.
// [RULE20] counter reads have no side effect; only status flags clear on read.
// [RULE21] clearing the counters re-arms their saturation flags.
package bert_rx_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_CONTROL0 = 10'h070;
  localparam logic [9:0] IDX_PATTERN_LO = 10'h074;
  localparam logic [9:0] IDX_PATTERN_HI = 10'h076;
  localparam logic [9:0] IDX_BIT_COUNT_LO = 10'h078;
  localparam logic [9:0] IDX_BIT_COUNT_HI = 10'h07A;
  localparam logic [9:0] IDX_STATUS = 10'h07C;
  localparam logic [9:0] IDX_ERROR_HIGH = 10'h07E;
  localparam logic [9:0] IDX_TOP_MASK = 10'h090;
  localparam int ADDR_W = 12;
  localparam int REG_W = 16;
  // tester_control0 fields
  localparam int CTL_LATCH_CLEAR = 1;
  localparam int CTL_SAT_IRQ_EN = 13;
  localparam int CTL_BIT_ERR_IRQ_EN = 14;
  localparam int CTL_LOCK_IRQ_EN = 15;
  localparam logic [15:0] CONTROL0_RESET = 16'h0000;
  localparam logic [31:0] PATTERN_RESET = 32'h0000_0000;
  localparam logic TOP_MASK_RESET = 1'b0;
  // status fields
  localparam int ST_SYNC = 0;
  localparam int ST_ERR_SAT = 1;
  localparam int ST_BIT_SAT = 2;
  localparam int ST_BIT_ERR = 3;
  localparam int ST_LOCK_LOST = 4;
  localparam int ST_ALL_ZEROS = 5;
  localparam int ST_ALL_ONES = 6;
  localparam int ST_ERR_LOW = 8;
  // counts
  localparam int BIT_COUNT_W = 32;
  localparam int ERR_COUNT_W = 24;
  localparam int LOCK_MATCH = 32;
  localparam int WINDOW_BITS = 64;
  localparam int WINDOW_ERRS = 6;
  localparam int RUN_LIMIT = 31;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : bert_rx_pkg

// File: src/lock_tracker.sv
module lock_tracker
  import bert_rx_pkg::*;
#(
  parameter int PAT_W = 32,
  parameter int MATCH_N = LOCK_MATCH,
  parameter int WIN_N = WINDOW_BITS,
  parameter int WIN_ERR_N = WINDOW_ERRS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic bit_valid,
  input wire logic bit_in,
  input wire logic [PAT_W-1:0] pattern,
  output logic locked,
  output logic mismatch,
  output logic search_start
);
  typedef enum logic {SEARCH, LOCKED} lock_state_t;
  localparam int PTR_W = $clog2(PAT_W);
  localparam int MC_W = $clog2(MATCH_N + 1);
  localparam int WC_W = $clog2(WIN_N);
  localparam int WE_W = $clog2(WIN_ERR_N + 1);

  lock_state_t state_ff;
  logic [PTR_W-1:0] ptr_ff;
  logic [MC_W-1:0] match_cnt_ff;
  logic [WC_W-1:0] win_cnt_ff;
  logic [WE_W-1:0] win_err_ff;
  logic miss;
  logic [WE_W-1:0] nxt_win_err;

  assign miss = bit_in != pattern[ptr_ff];
  assign nxt_win_err = win_err_ff + WE_W'(miss);
  assign locked = state_ff == LOCKED;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mismatch <= 1'b0;
    end else begin
      mismatch <= bit_valid & miss;
    end
  end

  // on a miss while hunting the pointer holds, so the phase slips one bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= SEARCH;
      ptr_ff <= '0;
      match_cnt_ff <= '0;
      win_cnt_ff <= '0;
      win_err_ff <= '0;
      search_start <= 1'b0;
    end else begin
      search_start <= 1'b0;
      if (bit_valid) begin
        case (state_ff)
          SEARCH: begin
            if (miss) begin
              match_cnt_ff <= '0;
            end else begin
              ptr_ff <= ptr_ff + PTR_W'(1);
              if (match_cnt_ff == MC_W'(MATCH_N - 1)) begin // see [RULE7]
                state_ff <= LOCKED;
                match_cnt_ff <= '0;
                win_cnt_ff <= '0;
                win_err_ff <= '0;
              end else begin
                match_cnt_ff <= match_cnt_ff + MC_W'(1);
              end
            end
          end
          LOCKED: begin
            ptr_ff <= ptr_ff + PTR_W'(1);
            if (nxt_win_err >= WE_W'(WIN_ERR_N)) begin // see [RULE8]
              state_ff <= SEARCH;
              search_start <= 1'b1;
              win_cnt_ff <= '0;
              win_err_ff <= '0;
            end else if (win_cnt_ff == WC_W'(WIN_N - 1)) begin
              win_cnt_ff <= '0;
              win_err_ff <= '0;
            end else begin
              win_cnt_ff <= win_cnt_ff + WC_W'(1);
              win_err_ff <= nxt_win_err;
            end
          end
          default: begin
            state_ff <= SEARCH;
          end
        endcase
      end
    end
  end
endmodule : lock_tracker

// File: src/pattern_test_rx_monitor.sv
// Added by the designer: the AXI4-Lite interface to the registers.
module pattern_test_rx_monitor
  import bert_rx_pkg::*;
#(
  parameter int BC_W = BIT_COUNT_W,
  parameter int EC_W = ERR_COUNT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);
  // software registers
  logic [15:0] control0_ff;
  logic [31:0] pattern_ff;
  logic top_irq_mask_ff;

  // live status and counters
  logic locked;
  logic mismatch;
  logic search_start;
  logic locked_d_ff;
  logic count_armed_ff;
  logic clear_d_ff;
  logic counter_clear;
  logic [BC_W-1:0] received_bit_count_ff;
  logic [EC_W-1:0] error_bit_count_ff;
  logic bit_count_saturated_ff;
  logic error_count_saturated_ff;
  logic bit_error_seen_ff;
  logic lock_lost_latched_ff;
  logic lock_change_ff;
  logic all_zeros_seen_ff;
  logic all_ones_seen_ff;
  logic [4:0] zero_run_ff;
  logic [4:0] one_run_ff;
  logic bit_d_ff;
  logic bit_valid_d_ff;

  // bus state
  logic aw_hold_ff;
  logic w_hold_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic aw_take;
  logic w_take;
  logic wr_fire;
  logic ar_take;
  logic nxt_aw_hold;
  logic nxt_w_hold;
  logic nxt_bvalid;
  logic nxt_rvalid;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [9:0] wr_idx;
  logic [9:0] rd_idx;
  logic wr_addr_ok;
  logic status_read;
  logic [15:0] rd_word;
  logic rd_ok;
  logic [15:0] status_word;
  logic [15:0] nxt_control0;
  logic [15:0] ctl_wdata;

  wire bc_full = &received_bit_count_ff;
  wire ec_full = &error_bit_count_ff;
  wire zero_run_full = zero_run_ff == 5'(RUN_LIMIT);
  wire one_run_full = one_run_ff == 5'(RUN_LIMIT);

  lock_tracker #(
    .PAT_W(32),
    .MATCH_N(LOCK_MATCH),
    .WIN_N(WINDOW_BITS),
    .WIN_ERR_N(WINDOW_ERRS)
  ) u_lock (
    .aclk(aclk),
    .aresetn(aresetn),
    .bit_valid(rx_bit_valid),
    .bit_in(rx_bit),
    .pattern(pattern_ff),
    .locked(locked),
    .mismatch(mismatch),
    .search_start(search_start)
  );

  // write channel: address and data taken in either order
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign wr_addr = aw_hold_ff ? awaddr_ff : s_axi_awaddr;
  assign wr_data = w_hold_ff ? wdata_ff : s_axi_wdata;
  assign wr_strb = w_hold_ff ? wstrb_ff : s_axi_wstrb;
  assign wr_fire = (aw_hold_ff | aw_take) & (w_hold_ff | w_take);
  assign wr_idx = wr_addr[11:2];
  assign nxt_aw_hold = (aw_hold_ff | aw_take) & ~wr_fire;
  assign nxt_w_hold = (w_hold_ff | w_take) & ~wr_fire;
  assign nxt_bvalid = wr_fire | (s_axi_bvalid & ~s_axi_bready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff <= nxt_w_hold;
      if (aw_take) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      s_axi_awready <= ~nxt_aw_hold & ~nxt_bvalid;
      s_axi_wready <= ~nxt_w_hold & ~nxt_bvalid;
      s_axi_bvalid <= nxt_bvalid;
      if (wr_fire) begin
        s_axi_bresp <= wr_addr_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_comb begin
    case (wr_idx)
      IDX_CONTROL0, IDX_PATTERN_LO, IDX_PATTERN_HI, IDX_TOP_MASK,
      IDX_BIT_COUNT_LO, IDX_BIT_COUNT_HI, IDX_STATUS, IDX_ERROR_HIGH: begin
        wr_addr_ok = 1'b1;
      end
      default: begin
        wr_addr_ok = 1'b0;
      end
    endcase
  end

  // byte lanes: only the low two lanes carry register bits
  assign ctl_wdata = {wr_strb[1] ? wr_data[15:8] : control0_ff[15:8],
                      wr_strb[0] ? wr_data[7:0] : control0_ff[7:0]};
  assign nxt_control0 = (wr_fire && wr_idx == IDX_CONTROL0) ?
                        ctl_wdata : control0_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control0_ff <= CONTROL0_RESET;
    end else begin
      control0_ff <= nxt_control0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pattern_ff <= PATTERN_RESET;
    end else if (wr_fire && wr_idx == IDX_PATTERN_LO) begin
      if (wr_strb[0]) begin
        pattern_ff[7:0] <= wr_data[7:0];
      end
      if (wr_strb[1]) begin
        pattern_ff[15:8] <= wr_data[15:8];
      end
    end else if (wr_fire && wr_idx == IDX_PATTERN_HI) begin
      if (wr_strb[0]) begin
        pattern_ff[23:16] <= wr_data[7:0];
      end
      if (wr_strb[1]) begin
        pattern_ff[31:24] <= wr_data[15:8];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      top_irq_mask_ff <= TOP_MASK_RESET;
    end else if (wr_fire && wr_idx == IDX_TOP_MASK && wr_strb[0]) begin
      top_irq_mask_ff <= wr_data[0];
    end
  end

  // read channel: one read at a time, data one cycle after the address
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign rd_idx = s_axi_araddr[11:2];
  assign nxt_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);
  assign status_read = ar_take && rd_idx == IDX_STATUS; // see [RULE20]

  assign status_word = {error_bit_count_ff[7:0], 1'b0, // see [RULE18]
                        all_ones_seen_ff, all_zeros_seen_ff,
                        lock_lost_latched_ff, bit_error_seen_ff,
                        bit_count_saturated_ff, error_count_saturated_ff,
                        locked};

  always_comb begin
    rd_ok = 1'b1;
    case (rd_idx)
      IDX_CONTROL0: rd_word = control0_ff;
      IDX_PATTERN_LO: rd_word = pattern_ff[15:0];
      IDX_PATTERN_HI: rd_word = pattern_ff[31:16];
      IDX_BIT_COUNT_LO: rd_word = 16'(received_bit_count_ff);
      IDX_BIT_COUNT_HI: rd_word = 16'(received_bit_count_ff >> 16);
      IDX_STATUS: rd_word = status_word;
      IDX_ERROR_HIGH: rd_word = 16'(error_bit_count_ff >> 8); // see [RULE18]
      IDX_TOP_MASK: rd_word = {15'h0000, top_irq_mask_ff};
      default: begin
        rd_word = 16'h0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~nxt_rvalid;
      s_axi_rvalid <= nxt_rvalid;
      if (ar_take) begin
        s_axi_rdata <= {16'h0000, rd_word};
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // counter clear on the rising edge of the latch-clear bit
  assign counter_clear = control0_ff[CTL_LATCH_CLEAR] & ~clear_d_ff; // see [RULE5]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clear_d_ff <= 1'b0;
      locked_d_ff <= 1'b0;
    end else begin
      clear_d_ff <= control0_ff[CTL_LATCH_CLEAR];
      locked_d_ff <= locked;
    end
  end

  // once armed by lock, counting never pauses on a later loss
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_armed_ff <= 1'b0;
    end else if (locked) begin
      count_armed_ff <= 1'b1; // see [RULE4]
    end
  end

  // mismatch arrives one cycle after its bit, so the bit count is aligned
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_valid_d_ff <= 1'b0;
      bit_d_ff <= 1'b0;
    end else begin
      bit_valid_d_ff <= rx_bit_valid;
      bit_d_ff <= rx_bit;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      received_bit_count_ff <= '0;
    end else if (counter_clear) begin
      received_bit_count_ff <= '0;
    end else if (bit_valid_d_ff && count_armed_ff && !bc_full) begin
      received_bit_count_ff <= received_bit_count_ff + BC_W'(1); // see [RULE1] [RULE3]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      error_bit_count_ff <= '0;
    end else if (counter_clear) begin
      error_bit_count_ff <= '0;
    end else if (mismatch && count_armed_ff && !ec_full) begin
      error_bit_count_ff <= error_bit_count_ff + EC_W'(1); // see [RULE2] [RULE3]
    end
  end

  // saturation flags set only on the step into full, so a clear re-arms them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_count_saturated_ff <= 1'b0;
      error_count_saturated_ff <= 1'b0;
    end else begin
      bit_count_saturated_ff <= (bit_count_saturated_ff & ~status_read) |
        (bit_valid_d_ff & count_armed_ff & ~counter_clear &
         (received_bit_count_ff == {{(BC_W-1){1'b1}}, 1'b0})); // see [RULE10] [RULE21]
      error_count_saturated_ff <= (error_count_saturated_ff & ~status_read) |
        (mismatch & count_armed_ff & ~counter_clear &
         (error_bit_count_ff == {{(EC_W-1){1'b1}}, 1'b0})); // see [RULE9] [RULE21]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_error_seen_ff <= 1'b0;
    end else begin
      bit_error_seen_ff <= (bit_error_seen_ff & ~status_read) |
                           (mismatch & locked_d_ff); // see [RULE12]
    end
  end

  // lock is lost at reset, so the flag starts set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_lost_latched_ff <= 1'b1;
      lock_change_ff <= 1'b0;
    end else begin
      lock_lost_latched_ff <= (lock_lost_latched_ff & ~status_read) |
                              search_start | ~locked; // see [RULE14]
      lock_change_ff <= (lock_change_ff & ~status_read) |
                        (locked ^ locked_d_ff); // see [RULE15]
    end
  end

  // run lengths of equal bits, saturating at the alarm limit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zero_run_ff <= '0;
      one_run_ff <= '0;
    end else if (rx_bit_valid) begin
      if (rx_bit) begin
        zero_run_ff <= '0;
        one_run_ff <= one_run_full ? one_run_ff : one_run_ff + 5'(1);
      end else begin
        one_run_ff <= '0;
        zero_run_ff <= zero_run_full ? zero_run_ff : zero_run_ff + 5'(1);
      end
    end
  end

  // a read only clears the alarm once the opposite bit has been seen
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      all_zeros_seen_ff <= 1'b0;
      all_ones_seen_ff <= 1'b0;
    end else begin
      all_zeros_seen_ff <= zero_run_full |
        (all_zeros_seen_ff & ~(status_read & zero_run_ff == 5'(0))); // see [RULE16]
      all_ones_seen_ff <= one_run_full |
        (all_ones_seen_ff & ~(status_read & one_run_ff == 5'(0))); // see [RULE17]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= top_irq_mask_ff & (
        (control0_ff[CTL_SAT_IRQ_EN] &
         (bit_count_saturated_ff | error_count_saturated_ff)) | // see [RULE11] [RULE19]
        (control0_ff[CTL_BIT_ERR_IRQ_EN] & bit_error_seen_ff) | // see [RULE13] [RULE19]
        (control0_ff[CTL_LOCK_IRQ_EN] & lock_change_ff)); // see [RULE15] [RULE19]
    end
  end

  // protection bits and the previous serial bit carry no meaning here
  wire unused_ok = &{1'b0, s_axi_awprot, s_axi_arprot, bit_d_ff, 1'b0};
endmodule : pattern_test_rx_monitor

// File: bench/bit_source.sv
module bit_source (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic go,
  input wire logic [11:0] count,
  input wire logic [7:0] err_every,
  input wire logic slow,
  input wire logic [31:0] pattern,
  output logic rx_bit_valid,
  output logic rx_bit,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] left_ff;
  logic [4:0] ptr_ff;
  logic [7:0] ph_ff;
  logic gap_ff;
  logic hit;
  logic send;
  assign busy = left_ff != 12'h000;
  assign hit = err_every != 8'h00 && ph_ff == err_every - 8'h01;
  assign send = busy && !(slow && gap_ff);
  always_ff @(posedge aclk) begin
    gap_ff <= aresetn & ~gap_ff;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left_ff <= 12'h000;
      ptr_ff <= 5'h00;
      ph_ff <= 8'h00;
      rx_bit_valid <= 1'b0;
      rx_bit <= 1'b0;
    end else begin
      rx_bit_valid <= 1'b0;
      // no stale level between bits
      rx_bit <= ~rx_bit;
      if (go) begin
        left_ff <= count;
        ph_ff <= 8'h00;
      end else if (send) begin
        rx_bit_valid <= 1'b1;
        // pattern bit 0 goes out first; hit flips one bit in k
        rx_bit <= pattern[ptr_ff] ^ hit;
        left_ff <= left_ff - 12'h001;
        ptr_ff <= ptr_ff + 5'h01;
        ph_ff <= hit ? 8'h00 : ph_ff + 8'h01;
      end
    end
  end
endmodule : bit_source

// File: bench/pattern_test_rx_monitor_assertions.sv
module pattern_test_rx_monitor_assertions
  import bert_rx_pkg::*;
#(
  parameter int BC_W = BIT_COUNT_W,
  parameter int EC_W = ERR_COUNT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic rx_bit_valid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic st_rd;
  assign st_rd = s_axi_arvalid && s_axi_arready
    && s_axi_araddr[11:2] == IDX_STATUS;
  a_write_resp: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write not answered");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read not answered");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_write_refused: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("ready while busy");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready while busy");
  a_write_done: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid ##[0:1] s_axi_awready) else $error("write stuck");
  a_read_done: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid ##[0:1] s_axi_arready) else $error("read stuck");
  a_upper_zero: assert property (s_axi_rvalid
    |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper half set");
  a_irq_cleared:
    assert property (!rx_bit_valid[*4] ##0 st_rd ##1 !rx_bit_valid
      |=> !irq) else $error("irq stays after status read");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_status: cover property (st_rd);
  c_irq: cover property ($rose(irq));
endmodule : pattern_test_rx_monitor_assertions

bind pattern_test_rx_monitor pattern_test_rx_monitor_assertions #(
  .BC_W(BC_W),
  .EC_W(EC_W)
) u_chk (
  .aclk, .aresetn, .rx_bit_valid, .s_axi_araddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .irq
);

// File: bench/tb.sv
module tb
  import bert_rx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BCW = 11;
  localparam int ECW = 9;
  logic aclk, aresetn, rx_bit_valid, rx_bit, irq, go, slow, busy;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr, count;
  logic [31:0] s_axi_wdata, s_axi_rdata, pattern;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
  logic [7:0] err_every;
  logic [15:0] seed, rd_data;
  int err_count, n_tests, nb, ne;
  pattern_test_rx_monitor #(.BC_W(BCW), .EC_W(ECW)) i_dut (
    .aclk, .aresetn, .rx_bit_valid, .rx_bit, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .irq
  );
  bit_source u_src (
    .aclk, .aresetn, .go, .count, .err_every, .slow, .pattern,
    .rx_bit_valid, .rx_bit, .busy
  );
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic int sat(input int v, input int w);
    return (v > (1 << w) - 1) ? (1 << w) - 1 : v;
  endfunction : sat
  function automatic logic [15:0] st(input logic [7:0] f);
    int e;
    e = sat(ne, ECW);
    return {e[7:0], f};
  endfunction : st
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [9:0] idx, input logic [15:0] d);
    int t;
    t = 0;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && t < 99);
    s_axi_bready <= 1'b0;
    rd_resp = s_axi_bresp;
    if (t == 99) err_count++;
    @(posedge aclk);
  endtask : wr
  task automatic chk(input logic [9:0] idx, input logic [15:0] exp,
                     input logic [15:0] msk);
    int t;
    t = 0;
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && t < 99);
    s_axi_rready <= 1'b0;
    rd_data = s_axi_rdata[15:0];
    rd_resp = s_axi_rresp;
    if (t == 99) err_count++;
    @(posedge aclk);
    cmp(rd_data & msk, exp);
  endtask : chk
  task automatic send(input int n, input logic [7:0] k);
    int t;
    t = 0;
    count <= n[11:0];
    err_every <= k;
    slow <= seed[0];
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    @(posedge aclk);
    do begin
      @(posedge aclk);
      t++;
    end while (busy && t < 9000);
    if (t == 9000) err_count++;
    repeat (4) @(posedge aclk);
    nb += n;
    ne += (k != 0) ? n / int'(k) : 0;
    seed = lfsr(seed);
  endtask : send
  task automatic cnts(input bit with_err);
    int b;
    int e;
    b = sat(nb, BCW);
    e = sat(ne, ECW);
    chk(IDX_BIT_COUNT_LO, b[15:0], 16'hFFFF);
    chk(IDX_BIT_COUNT_HI, b[31:16], 16'hFFFF);
    if (with_err) chk(IDX_ERROR_HIGH, e[23:8], 16'hFFFF);
  endtask : cnts
  task automatic clear(input logic [15:0] en);
    wr(IDX_CONTROL0, en);
    wr(IDX_CONTROL0, en | 16'(1 << CTL_LATCH_CLEAR));
    nb = 0;
    ne = 0;
  endtask : clear
  task automatic set_pat(input logic [31:0] p);
    pattern <= p;
    wr(IDX_PATTERN_LO, p[15:0]);
    wr(IDX_PATTERN_HI, p[31:16]);
  endtask : set_pat
  initial begin
    repeat (40000) @(posedge aclk);
    err_count++;
    end_of_test();
  end
  initial begin
    int n;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_rready, go, slow, aresetn} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, count} = 36'h0;
    {s_axi_wdata, pattern, err_every} = 72'h0;
    {err_count, n_tests, nb, ne} = '0;
    seed = 16'h0006;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(IDX_STATUS, 16'h0010, 16'hFFFF);
    chk(IDX_CONTROL0, CONTROL0_RESET, 16'hFFFF);
    chk(IDX_TOP_MASK, 16'h0000, 16'h0001);
    chk(10'h3FF, 16'h0000, 16'hFFFF);
    cmp({14'h0, rd_resp}, {14'h0, RESP_SLVERR});
    wr(10'h3FF, 16'hFFFF);
    cmp({14'h0, rd_resp}, {14'h0, RESP_SLVERR});
    $display("test reset done");
    seed = lfsr(seed);
    set_pat({seed, lfsr(seed)});
    send(31, 8'h00);
    chk(IDX_STATUS, 16'h0010, 16'hFFFF);
    send(1, 8'h00);
    chk(IDX_STATUS, 16'h0011, 16'hFFFF);
    $display("test lock done");
    clear(16'hE000);
    n = 40 + int'(seed % 16'd160);
    send(n, 8'd13);
    cmp({15'h0, irq}, 16'h0000);
    wr(IDX_TOP_MASK, 16'h0001);
    repeat (2) @(posedge aclk);
    cmp({15'h0, irq}, 16'h0001);
    cnts(1'b1);
    chk(IDX_STATUS, st(8'h09), 16'hFFFF);
    repeat (2) @(posedge aclk);
    cmp({15'h0, irq}, 16'h0000);
    $display("test errors done");
    send(64, 8'd1);
    cmp({15'h0, irq}, 16'h0001);
    cnts(1'b0);
    chk(IDX_STATUS, 16'h0010, 16'h0011);
    send(1200, 8'h00);
    cmp({15'h0, irq}, 16'h0001);
    cnts(1'b0);
    chk(IDX_STATUS, 16'h0011, 16'h00FD);
    chk(IDX_STATUS, 16'h0001, 16'h00FD);
    $display("test lock loss done");
    clear(16'h2000);
    send(2100, 8'd1);
    ne = 1 << 20;
    cmp({15'h0, irq}, 16'h0001);
    cnts(1'b1);
    chk(IDX_STATUS, st(8'h06), 16'hFF06);
    send(20, 8'd1);
    chk(IDX_STATUS, 16'h0000, 16'h0006);
    cmp({15'h0, irq}, 16'h0000);
    clear(16'h2000);
    cnts(1'b1);
    send(2100, 8'd1);
    chk(IDX_STATUS, 16'h0006, 16'h0006);
    $display("test saturation done");
    set_pat(32'hFFFF_FFFF);
    send(40, 8'h00);
    chk(IDX_STATUS, 16'h0040, 16'h0060);
    set_pat(32'h0000_0000);
    send(40, 8'h00);
    chk(IDX_STATUS, 16'h0060, 16'h0060);
    chk(IDX_STATUS, 16'h0020, 16'h0060);
    $display("test runs done");
    end_of_test();
  end
endmodule : tb
